// [swl_top.sv]
// serial slave, write locks, input loss detector and output parking
`timescale 1ns/10ps
`include "swl_params.svh"
// the block answers a two-wire management bus, keeps two write-lock
// bits and a sticky input-loss flag, and parks the output legs low
// once a reference clock that has run goes missing; every pin input is synchronised
// before use, so bus edges are judged a few core cycles late
module swl_top #(
  parameter logic [6:0] SMB_ADDR = 7'h5A // slave address, value arbitrary
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // serial management pins
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // reference clock and loss indicator
  input wire logic referenceInputClock,
  output logic inputLossIndicatorOut,
  output logic inputLossIndicatorOe,
  // parked differential path
  output logic outLegP,
  output logic outLegN,
  // write port to the other control bytes
  output logic cfgWrStrobe,
  output logic [7:0] cfgWrAddr,
  output logic [7:0] cfgWrData
);
  import swl_pkg::*;

  // last timer value before loss is declared; the timer counts core
  // cycles, so the judgement window scales with the core clock period
  localparam logic [8:0] LOSS_LAST = 9'(`SWL_LOSS_CYC - 1);

  swl_state_t state_r; // slave state
  swl_state_t state_nxt;
  logic sclS1, sclS2, sclS3; // scl synchroniser and edge stage
  logic sdaS1, sdaS2, sdaS3; // sda synchroniser and edge stage
  logic refS1, refS2, refS3; // reference clock synchroniser
  logic [7:0] shift_r; // received byte
  logic [7:0] tx_r; // byte being sent
  logic [3:0] cnt_r; // bits seen in current byte
  logic [7:0] ptr_r; // register pointer
  logic stickyLock_r; // lock that only reset clears
  logic clearableWriteLock_r; // lock toggled by one writes
  logic inputLossEventFlag_r; // sticky loss event
  logic seenEdge_r; // a reference edge arrived since reset
  logic [8:0] lossTimer_r; // cycles since last reference edge
  logic inputClockLoss_r; // loss detector output
  logic autoOutputParking_r; // legs held low/low

  // bus events; the third stage only remembers the last synced level,
  // so an edge is seen in the same cycle that the synced level changes, and
  // a start or stop needs scl high on both stages to rule out a race
  // between the two pins
  wire sclRise = sclS2 & ~sclS3;
  wire sclFall = ~sclS2 & sclS3;
  wire busStart = sclS2 & sclS3 & sdaS3 & ~sdaS2;
  wire busStop = sclS2 & sclS3 & ~sdaS3 & sdaS2;
  wire byteDone = (cnt_r == `SWL_BITS_PER_BYTE);
  wire addrMatch = (shift_r[7:1] == SMB_ADDR);
  wire anyLock = stickyLock_r | clearableWriteLock_r;
  // write decode; a byte counts as taken on the scl fall that ends its
  // eighth bit, before the acknowledge, so a stop in place of the ack
  // still leaves the byte written
  wire wrTake = sclFall & byteDone & (state_r == SWL_WDATA);
  wire wrSticky = wrTake & (ptr_r == `SWL_OFS_STICKY);
  wire wrClrLoss = wrTake & (ptr_r == `SWL_OFS_CLRLOSS);
  wire wrOther = wrTake & ~wrSticky & ~wrClrLoss & ~anyLock;
  // loss detector events
  wire refEdge = refS2 ^ refS3;
  wire lossEvent = seenEdge_r & ~refEdge & (lossTimer_r == LOSS_LAST) & ~inputClockLoss_r;
  // read data mux, reserved bits zero
  wire [7:0] stickyByte = {7'h00, stickyLock_r};
  wire [7:0] clrLossByte = {6'h00, inputLossEventFlag_r, clearableWriteLock_r};
  wire [7:0] nextPtr = ptr_r + 8'h01;
  // a master ack steps the pointer on the same edge that loads the next
  // byte, so in that state the mux already looks one byte ahead
  wire [7:0] rdPtr = (state_r == SWL_RDATA_ACK) ? nextPtr : ptr_r;
  wire [7:0] readByte = (rdPtr == `SWL_OFS_STICKY) ? stickyByte :
                        (rdPtr == `SWL_OFS_CLRLOSS) ? clrLossByte : `SWL_RST_BYTE;

  // two-flop synchronisers, third stage only for edge finding
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      {sclS1, sclS2, sclS3} <= 3'h7;
      {sdaS1, sdaS2, sdaS3} <= 3'h7;
      {refS1, refS2, refS3} <= 3'h0;
    end else begin
      {sclS3, sclS2, sclS1} <= {sclS2, sclS1, sclIn};
      {sdaS3, sdaS2, sdaS1} <= {sdaS2, sdaS1, sdaIn};
      {refS3, refS2, refS1} <= {refS2, refS1, referenceInputClock};
    end
  end

  // next slave state; start and stop win over any bit edge, so a
  // cut frame always returns the slave to a known state
  // the read or write bit sits one place up by the ack edge, since the
  // acknowledge bit itself has been shifted in behind it
  always_comb begin
    state_nxt = state_r;
    if (busStart) begin
      state_nxt = SWL_ADDR;
    end else if (busStop) begin
      state_nxt = SWL_IDLE;
    end else if (sclFall) begin
      case (state_r)
        SWL_ADDR: begin
          if (byteDone) begin
            state_nxt = addrMatch ? SWL_ADDR_ACK : SWL_IDLE;
          end
        end
        SWL_ADDR_ACK: begin
          state_nxt = shift_r[1] ? SWL_RDATA : SWL_CMD;
        end
        SWL_CMD: begin
          if (byteDone) begin
            state_nxt = SWL_CMD_ACK;
          end
        end
        SWL_CMD_ACK: state_nxt = SWL_WDATA;
        SWL_WDATA: begin
          if (byteDone) begin
            state_nxt = SWL_WDATA_ACK;
          end
        end
        SWL_WDATA_ACK: state_nxt = SWL_WDATA;
        SWL_RDATA: begin
          if (byteDone) begin
            state_nxt = SWL_RDATA_ACK;
          end
        end
        // master ack sampled into shift_r[0] on the rising edge
        SWL_RDATA_ACK: state_nxt = shift_r[0] ? SWL_IDLE : SWL_RDATA;
        default: state_nxt = SWL_IDLE;
      endcase
    end
  end

  // state register
  // one-hot codes keep every state test down to a single bit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= SWL_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // bit counter and receive shifter, sampled on scl rise
  // the counter clears on a start and on each state change at an scl fall, so each byte and each ack
  // counts from zero; the shifter never clears, eight bits refill it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 4'h0;
      shift_r <= `SWL_RST_BYTE;
    end else if (busStart || (sclFall && state_nxt != state_r)) begin
      cnt_r <= 4'h0;
    end else if (sclRise) begin
      cnt_r <= cnt_r + 4'h1;
      shift_r <= {shift_r[6:0], sdaS2};
    end
  end

  // pointer: set by command byte, advanced after each data byte
  // a read that ends without a master ack leaves the pointer on the
  // byte just read, so a plain repeated read returns that byte again
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ptr_r <= `SWL_RST_BYTE;
    end else if (sclFall && byteDone && state_r == SWL_CMD) begin
      ptr_r <= shift_r;
    end else if (sclFall && state_r == SWL_WDATA_ACK) begin
      ptr_r <= nextPtr;
    end else if (sclFall && state_r == SWL_RDATA_ACK && !shift_r[0]) begin
      ptr_r <= nextPtr;
    end
  end

  // sda drive: changes only while scl is low, open drain low only
  // read bits go out msb first: the first from the mux, the rest from a
  // captured copy, so a lock change in mid-byte cannot tear the byte
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sdaOut <= 1'b0;
      sdaOe <= 1'b0;
      tx_r <= `SWL_RST_BYTE;
    end else if (busStart || busStop) begin
      sdaOe <= 1'b0;
    end else if (sclFall) begin
      sdaOut <= 1'b0;
      case (state_nxt)
        // acknowledge address, command and data bytes
        SWL_ADDR_ACK, SWL_CMD_ACK, SWL_WDATA_ACK: sdaOe <= 1'b1;
        SWL_RDATA: begin
          if (state_r != SWL_RDATA) begin
            tx_r <= {readByte[6:0], 1'b0};
            sdaOe <= ~readByte[7];
          end else begin
            tx_r <= {tx_r[6:0], 1'b0};
            sdaOe <= ~tx_r[7];
          end
        end
        default: sdaOe <= 1'b0;
      endcase
    end
  end

  // lock bits; the clearable byte stays writable while locked
  // the clearable lock toggles on each write of one, so one and the same
  // write sets and clears it; the sticky lock takes a write only while
  // both locks are off, which costs nothing as it cannot be cleared
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      stickyLock_r <= 1'b0;
      clearableWriteLock_r <= 1'b0;
    end else begin
      if (wrSticky && !anyLock && cfgDataLock(shift_r)) begin
        stickyLock_r <= 1'b1;
      end
      if (wrClrLoss && cfgDataLock(shift_r)) begin
        clearableWriteLock_r <= ~clearableWriteLock_r;
      end
    end
  end

  // lock bit of a written data byte
  function automatic logic cfgDataLock(input logic [7:0] d);
    cfgDataLock = d[`SWL_BIT_LOCK];
  endfunction

  // loss flag: a new event wins over a same-cycle clear
  // so software never loses an event that lands while it is clearing
  // an older one; it simply sees the flag still set on its next read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      inputLossEventFlag_r <= 1'b0;
    end else if (lossEvent) begin
      inputLossEventFlag_r <= 1'b1;
    end else if (wrClrLoss && shift_r[`SWL_BIT_LOSS]) begin
      inputLossEventFlag_r <= 1'b0;
    end
  end

  // write port to the rest of the control space, gated by the locks
  // the two lock bytes never appear here; address and data hold after
  // the strobe until the next accepted write
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cfgWrStrobe <= 1'b0;
      cfgWrAddr <= `SWL_RST_BYTE;
      cfgWrData <= `SWL_RST_BYTE;
    end else begin
      cfgWrStrobe <= wrOther;
      if (wrOther) begin
        cfgWrAddr <= ptr_r;
        cfgWrData <= shift_r;
      end
    end
  end

  // loss detector: the timer restarts on every reference edge
  // both edges count, so a stopped clock is judged after the full window
  // whichever level it stops at; before the first edge the timer stays
  // at zero and no loss is judged
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seenEdge_r <= 1'b0;
      lossTimer_r <= 9'h000;
      inputClockLoss_r <= 1'b0;
    end else if (refEdge) begin
      seenEdge_r <= 1'b1;
      lossTimer_r <= 9'h000;
      inputClockLoss_r <= 1'b0;
    end else if (seenEdge_r && lossTimer_r == LOSS_LAST) begin
      inputClockLoss_r <= 1'b1;
    end else if (seenEdge_r) begin
      lossTimer_r <= lossTimer_r + 9'h001;
    end
  end

  // indicator pin and output parking; before the first edge the
  // pin stays released since no loss can yet be judged
  // the legs follow the synced reference and lag the pin by a few core
  // cycles; parking lands one cycle after the indicator asserts
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      inputLossIndicatorOut <= 1'b0;
      inputLossIndicatorOe <= 1'b0;
      autoOutputParking_r <= 1'b0;
      outLegP <= 1'b0;
      outLegN <= 1'b0;
    end else begin
      inputLossIndicatorOut <= 1'b0;
      inputLossIndicatorOe <= inputClockLoss_r;
      autoOutputParking_r <= inputClockLoss_r;
      outLegP <= ~autoOutputParking_r & refS2;
      outLegN <= ~autoOutputParking_r & ~refS2;
    end
  end
endmodule

// [swl_params.svh]
// constants for the write-lock and input-loss status register block
// Behaviour
// - sticky lock bit rejects later control writes
// - sticky lock ignores clears, reset only
// - clearable lock toggles on each one write
// - either lock bit blocks control writes
// - detector sets loss event flag, resets zero
// - writing one clears loss flag, zero keeps
// - detector drives active-low loss indicator pin
// - indicator stays released until first clock edge
// - parking drives both legs low after loss
`ifndef SWL_PARAMS_SVH
`define SWL_PARAMS_SVH
`define SWL_OFS_STICKY 8'h26
`define SWL_OFS_CLRLOSS 8'h27
`define SWL_BIT_LOCK 0
`define SWL_BIT_LOSS 1
`define SWL_RST_BYTE 8'h00
`define SWL_CLK_MHZ 200
`define SWL_LOSS_TIME_NS 1000
`define SWL_LOSS_CYC ((`SWL_LOSS_TIME_NS * `SWL_CLK_MHZ) / 1000)
`define SWL_BITS_PER_BYTE 4'h8
`endif

// [swl_pkg.sv]
// types for the write-lock and input-loss status register block
package swl_pkg;
  // serial slave states, one-hot
  typedef enum logic [8:0] {
    SWL_IDLE = 9'h001,
    SWL_ADDR = 9'h002,
    SWL_ADDR_ACK = 9'h004,
    SWL_CMD = 9'h008,
    SWL_CMD_ACK = 9'h010,
    SWL_WDATA = 9'h020,
    SWL_WDATA_ACK = 9'h040,
    SWL_RDATA = 9'h080,
    SWL_RDATA_ACK = 9'h100
  } swl_state_t;
endpackage

// [swl_props.sv]
// checker for lock, loss and parking behaviour at the block ports
`timescale 1ns/10ps
module swl_props (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // pins and config port
  input wire logic sdaOut,
  input wire logic referenceInputClock,
  input wire logic inputLossIndicatorOut,
  input wire logic inputLossIndicatorOe,
  input wire logic outLegP,
  input wire logic outLegN,
  input wire logic cfgWrStrobe,
  input wire logic [7:0] cfgWrAddr
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  logic refLast_r; // raw reference level one cycle ago
  logic refSeen_r; // raw reference edge since reset
  logic [8:0] quiet_r; // cycles since last raw edge, saturating
  // raw edge watch, kept apart from the design's own synchroniser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      refLast_r <= 1'b0;
      refSeen_r <= 1'b0;
      quiet_r <= 9'h000;
    end else begin
      refLast_r <= referenceInputClock;
      refSeen_r <= refSeen_r | (refLast_r ^ referenceInputClock);
      quiet_r <= (refLast_r ^ referenceInputClock) ? 9'h000 : quiet_r + {8'h00, ~&quiet_r};
    end
  end
  chk_strobe_single: assert property (cfgWrStrobe |=> !cfgWrStrobe)
    else $error("strobe too long");
  chk_lock_bytes_out: assert property (cfgWrStrobe |-> cfgWrAddr[7:1] != 7'h13)
    else $error("lock byte on config port");
  chk_pins_low: assert property (!sdaOut && !inputLossIndicatorOut)
    else $error("open drain driven high");
  chk_no_early_loss: assert property (!refSeen_r |-> !inputLossIndicatorOe)
    else $error("loss pin before first edge");
  chk_loss_not_early: assert property (
    $rose(inputLossIndicatorOe) |-> quiet_r >= 9'h0C3)
    else $error("loss too soon");
  chk_loss_in_time: assert property (
    refSeen_r && quiet_r == 9'h0D2 |-> inputLossIndicatorOe)
    else $error("loss missed");
  chk_edge_releases: assert property (
    inputLossIndicatorOe && quiet_r == 9'h000 |-> ##[1:8] !inputLossIndicatorOe)
    else $error("loss kept after edge");
  chk_parked_low: assert property (
    inputLossIndicatorOe && $past(inputLossIndicatorOe) |-> !outLegP && !outLegN)
    else $error("legs not parked");
  chk_legs_follow: assert property (
    !inputLossIndicatorOe && $past(!inputLossIndicatorOe) && $past(!rst)
    |-> outLegP != outLegN)
    else $error("legs not complementary");
  cover property (cfgWrStrobe);
  cover property ($rose(inputLossIndicatorOe));
  cover property ($fell(inputLossIndicatorOe));
endmodule

// [swl_host.sv]
// serial management host model on the bus pins
`timescale 1ns/10ps
module swl_host (
  // clock
  input wire logic core_clk,
  // bus pins
  input wire logic sdaOe,
  output logic sclIn,
  output logic sdaIn
);
  logic sdaDrv; // host drive, 1 = released
  // pulled-up wire: released line reads high
  assign sdaIn = sdaDrv & ~sdaOe;
  initial begin
    sclIn = 1'b1;
    sdaDrv = 1'b1;
  end
  // half bus period, slow so the 2FF sync sees every level
  task automatic hw();
    repeat (20) @(posedge core_clk);
  endtask
  // 1: start or repeated start, 0: stop; clock stands high after stop
  task automatic cond(input logic a);
    sdaDrv <= a;
    hw();
    sclIn <= 1'b1;
    hw();
    sdaDrv <= ~a;
    hw();
    sclIn <= ~a;
  endtask
  // one bit, line sampled while clock high
  task automatic bitx(input logic b, output logic r);
    sdaDrv <= b;
    hw();
    sclIn <= 1'b1;
    hw();
    r = sdaIn;
    sclIn <= 1'b0;
  endtask
  // byte msb first, then the ninth bit
  task automatic xfer(input logic [7:0] d, input logic nine, output logic [7:0] q,
    output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(nine, r);
    ack = ~r;
  endtask
endmodule

// [smbus_write_lock_and_loss_status_tb.sv]
// self-checking bench for the lock and loss status block
`timescale 1ns/10ps
`define CHK(nm, e, s) begin samplesChecked++; if ((s) !== (e)) begin errTotal++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, s); end end
module smbus_write_lock_and_loss_status_tb;
  localparam logic [6:0] DEV_ADDR = 7'h5A; // slave address, value arbitrary
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic refClk = 1'b0; // reference clock, still while refOn low
  logic refOn = 1'b0;
  logic sclIn, sdaIn, sdaOut, sdaOe, lossOut, lossOe, legP, legN, stb, ack;
  logic [7:0] cfgA, cfgD, stbA, stbD, q, d;
  logic stk = 1'b0, clr = 1'b0, input_clock_loss = 1'b0; // expected register bits
  int errTotal = 0, samplesChecked = 0, stbCnt = 0, n;
  initial forever #2.5 core_clk = ~core_clk;
  // offset by 1 ns so reference edges never meet core edges
  initial begin
    #1;
    forever #62.5 refClk = refOn ? ~refClk : refClk;
  end
  // count config strobes and keep the last address and data
  always @(posedge core_clk) if (stb === 1'b1) begin
    stbCnt++;
    {stbA, stbD} = {cfgA, cfgD};
  end
  swl_top #(.SMB_ADDR(DEV_ADDR)) dut_u (.core_clk(core_clk), .rst(rst), .sclIn(sclIn),
    .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .referenceInputClock(refClk),
    .inputLossIndicatorOut(lossOut), .inputLossIndicatorOe(lossOe), .outLegP(legP),
    .outLegN(legN), .cfgWrStrobe(stb), .cfgWrAddr(cfgA), .cfgWrData(cfgD));
  swl_host host_u (.core_clk(core_clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
  function automatic logic [7:0] expRd(input logic [7:0] a);
    return a == 8'h26 ? {7'h00, stk} : a == 8'h27 ? {6'h00, input_clock_loss, clr} : 8'h00;
  endfunction
  // start, write address and command byte, each one acknowledged
  task automatic hdr(input logic [7:0] a);
    host_u.cond(1'b1);
    host_u.xfer({DEV_ADDR, 1'b0}, 1'b1, q, ack);
    `CHK("addrAck", 1'b1, ack)
    host_u.xfer(a, 1'b1, q, ack);
    `CHK("cmdAck", 1'b1, ack)
  endtask
  // write one byte; a nonzero rd reads the byte instead and checks it against the model
  task automatic acc(input logic [7:0] a, input logic [7:0] v, input bit rd);
    hdr(a);
    if (rd) begin
      host_u.cond(1'b1);
      host_u.xfer({DEV_ADDR, 1'b1}, 1'b1, q, ack);
      `CHK("rdAddrAck", 1'b1, ack)
    end
    host_u.xfer(rd ? 8'hFF : v, 1'b1, q, ack);
    if (!rd) `CHK("dataAck", 1'b1, ack)
    host_u.cond(1'b0);
    if (rd) `CHK("readback", expRd(a), q)
  endtask
  task automatic finishTest();
    $display("checks %0d errors %0d", samplesChecked, errTotal);
    if (errTotal == 0 && samplesChecked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    void'($urandom(29817));
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    acc(8'h26, 8'h00, 1);
    acc(8'h27, 8'h00, 1);
    `CHK("lossPin", 1'b0, lossOe)
    // two-byte write: the pointer steps once per data byte
    d = 8'($urandom);
    n = stbCnt;
    hdr(8'h40);
    host_u.xfer(8'h3C, 1'b1, q, ack);
    host_u.xfer(d, 1'b1, q, ack);
    host_u.cond(1'b0);
    `CHK("burstWr", 2, stbCnt - n)
    `CHK("burstPort", {8'h41, d}, {stbA, stbD})
    // a foreign address gets no acknowledge
    host_u.cond(1'b1);
    host_u.xfer({DEV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, ack);
    host_u.cond(1'b0);
    `CHK("foreignAck", 1'b0, ack)
    for (int i = 0; i < 6; i++) begin
      if (i == 2 || i == 4) begin
        acc(8'h27, 8'h01, 0);
        clr = ~clr;
        acc(8'h27, 8'h00, 1);
      end
      d = 8'($urandom);
      n = stbCnt;
      acc(8'h10 + 8'(i), d, 0);
      `CHK("strobes", 32'(!clr), stbCnt - n)
      if (!clr) `CHK("cfgPort", {8'h10 + 8'(i), d}, {stbA, stbD})
    end
    refOn = 1'b1;
    repeat (100) @(posedge core_clk);
    `CHK("lossPin", 1'b0, lossOe)
    refOn = 1'b0;
    repeat (300) @(posedge core_clk);
    input_clock_loss = 1'b1;
    `CHK("lossPin", 1'b1, lossOe)
    `CHK("legs", 2'b00, {legP, legN})
    acc(8'h26, 8'h01, 0);
    stk = 1'b1;
    acc(8'h26, 8'h00, 0);
    acc(8'h26, 8'h00, 1);
    n = stbCnt;
    acc(8'h30, 8'($urandom), 0);
    `CHK("lockedStrobes", 0, stbCnt - n)
    acc(8'h27, 8'h00, 1);
    acc(8'h27, 8'h00, 0);
    acc(8'h27, 8'h00, 1);
    // two-byte read: a master ack moves on to the next byte
    hdr(8'h26);
    host_u.cond(1'b1);
    host_u.xfer({DEV_ADDR, 1'b1}, 1'b1, q, ack);
    host_u.xfer(8'hFF, 1'b0, q, ack);
    `CHK("burstRd0", expRd(8'h26), q)
    host_u.xfer(8'hFF, 1'b1, q, ack);
    host_u.cond(1'b0);
    `CHK("burstRd1", expRd(8'h27), q)
    refOn = 1'b1;
    repeat (100) @(posedge core_clk);
    `CHK("lossPin", 1'b0, lossOe)
    acc(8'h27, 8'h02, 0);
    input_clock_loss = 1'b0;
    acc(8'h27, 8'h00, 1);
    finishTest();
  end
  // hang guard
  initial begin
    #500000;
    errTotal++;
    finishTest();
  end
endmodule
bind swl_top swl_props chk_u (.core_clk(core_clk), .rst(rst), .sdaOut(sdaOut),
  .referenceInputClock(referenceInputClock), .inputLossIndicatorOut(inputLossIndicatorOut),
  .inputLossIndicatorOe(inputLossIndicatorOe), .outLegP(outLegP), .outLegN(outLegN),
  .cfgWrStrobe(cfgWrStrobe), .cfgWrAddr(cfgWrAddr));
